/* File: rtl/event_input_sync.sv */
// Purpose: synchronise active-low event pins and detect their edges
// Assumes: pins are asynchronous to clk
// Notes: first flop of each chain feeds only the second flop
`timescale 1ns/1ps
module event_input_sync (
    input wire logic clk, // system clock
    input wire logic rst, // async reset, active high
    input wire logic [3:0] pins_n, // gate, startup, hold, clear pins, active low
    output event_trigger_pkg::event_levels_t levels, // active-high levels
    output event_trigger_pkg::event_edges_t edges // one-cycle edge pulses
);
    logic [3:0] meta_reg, meta_next;
    logic [3:0] sync_reg, sync_next;
    logic [3:0] prev_reg, prev_next;
    logic [3:0] act;

    // next values: two-flop chains plus a delayed copy for edges
    always_comb begin
        meta_next = pins_n;
        sync_next = meta_reg;
        prev_next = sync_reg;
    end

    // pins idle high, so reset to inactive
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_reg <= 4'hF;
            sync_reg <= 4'hF;
            prev_reg <= 4'hF;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
            prev_reg <= prev_next;
        end
    end

    // low means active on every event input
    assign act = ~sync_reg;
    assign levels = '{gate: act[3], startup: act[2], hold: act[1], clear: act[0]};
    assign edges = '{gate_on: prev_reg[3] & ~sync_reg[3],
                     gate_off: ~prev_reg[3] & sync_reg[3],
                     startup_on: prev_reg[2] & ~sync_reg[2],
                     hold_on: prev_reg[1] & ~sync_reg[1]};
endmodule : event_input_sync

/* File: rtl/event_trigger_measure_hold.sv */
// Purpose: decide when readings are taken, held, reduced to extremes or dropped
// Assumes: sample_in is valid each cycle sample_valid is high, same clock domain
// Notes: dc output is the displayed value, clipped at zero, scaled by dc_gain
`timescale 1ns/1ps
module event_trigger_measure_hold (
    input wire logic clk, // 125 MHz system clock
    input wire logic rst, // async reset, active high
    input wire logic gate_n, // trigger gate pin, active low
    input wire logic startup_delay_in_n, // startup delay pin, active low
    input wire logic hold_n, // hold pin, active low
    input wire logic clear_n, // reset event pin, active low
    input wire logic [2:0] mode_sel, // trigger mode setting
    input wire logic mode_load, // one-cycle strobe to take mode_sel
    input wire logic [event_trigger_pkg::STARTUP_W-1:0] startup_tenths, // startup period, 0.1 s units
    input wire logic signed [event_trigger_pkg::DATA_W-1:0] sample_in, // new reading
    input wire logic sample_valid, // reading strobe
    input wire logic scaling_error, // scaling error level, includes burnout
    input wire logic burnout, // sensor burnout level
    input wire logic alarm_event, // alarm trip pulse to latch
    input wire logic [event_trigger_pkg::OUT_W-1:0] dc_gain, // dc scale per display count
    output logic [2:0] mode, // active mode
    output logic signed [event_trigger_pkg::DATA_W-1:0] display_value, // shown reading
    output logic display_valid, // measured data exists
    output logic display_error, // display shows error
    output logic display_burnout, // display shows burnout
    output logic signed [event_trigger_pkg::DATA_W-1:0] max_value, // stored maximum
    output logic signed [event_trigger_pkg::DATA_W-1:0] min_value, // stored minimum
    output logic extremes_valid, // max and min hold data
    output logic alarm_latched, // latched alarm
    output logic [event_trigger_pkg::OUT_W-1:0] dc_out, // analog output code
    output logic gate_lamp, // gate indicator
    output logic measuring // block is taking readings
);
    localparam int DW = event_trigger_pkg::DATA_W;
    localparam int OW = event_trigger_pkg::OUT_W;
    localparam int TICK_W = $clog2(event_trigger_pkg::TENTH_S_CYCLES);
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(event_trigger_pkg::TENTH_S_CYCLES - 1);

    event_trigger_pkg::event_levels_t lv;
    event_trigger_pkg::event_edges_t eg;

    event_input_sync event_input_sync_inst (
        .clk(clk),
        .rst(rst),
        .pins_n({gate_n, startup_delay_in_n, hold_n, clear_n}),
        .levels(lv),
        .edges(eg)
    );

    // mode register state
    logic [2:0] mode_reg, mode_next;
    // startup suppression timer
    logic [TICK_W-1:0] tick_reg, tick_next;
    logic [event_trigger_pkg::STARTUP_W-1:0] tenth_reg, tenth_next;
    logic sup_reg, sup_next;
    // hold freeze state
    logic held_gate_reg, held_gate_next;
    // gate level as measured one cycle back; edges of the frozen view come from it
    logic eff_prev_reg, eff_prev_next;
    // gate-period accumulation
    logic win_reg, win_next;
    logic win_err_reg, win_err_next;
    logic win_any_reg, win_any_next;
    logic signed [DW-1:0] wmax_reg, wmax_next, wmin_reg, wmin_next;
    // presented results
    logic signed [DW-1:0] disp_reg, disp_next, hold_val_reg, hold_val_next;
    logic dvalid_reg, dvalid_next, hold_ok_reg, hold_ok_next;
    logic signed [DW-1:0] max_reg, max_next, min_reg, min_next;
    logic ext_reg, ext_next, alarm_reg, alarm_next;
    logic [OW-1:0] dc_reg, dc_next;

    logic is_cont, gate_eff, gate_rise_eff, gate_fall_eff, take, show_held;
    logic [event_trigger_pkg::STARTUP_W-1:0] period;
    logic [DW+OW-1:0] dc_prod;

    // mode setting; reset loads continuous, unknown codes refused
    always_comb begin
        mode_next = mode_reg;
        if (mode_load && mode_sel <= event_trigger_pkg::SPAN_HOLD_MODE) begin
            mode_next = mode_sel;
        end
    end

    assign is_cont = (mode_reg == event_trigger_pkg::CONTINUOUS_MODE);
    // values above 99.9 s are clipped rather than wrapped
    assign period = (startup_tenths > event_trigger_pkg::STARTUP_MAX) ?
                    event_trigger_pkg::STARTUP_MAX : startup_tenths;

    // startup timer: restarts on a falling edge with a nonzero period, except in continuous mode under hold; counts tenths of a second
    always_comb begin
        tick_next = tick_reg;
        tenth_next = tenth_reg;
        sup_next = sup_reg;
        if (eg.startup_on && !(is_cont && lv.hold) && period != '0) begin
            sup_next = 1'b1;
            tick_next = '0;
            tenth_next = period;
        end else if (sup_reg) begin
            if (tick_reg == TICK_LAST) begin
                tick_next = '0;
                tenth_next = tenth_reg - 1'b1;
                if (tenth_reg == 1) begin
                    sup_next = 1'b0;
                end
            end else begin
                tick_next = tick_reg + 1'b1;
            end
        end
    end

    // gate as seen by the measurement: frozen by hold, dropped during reset input
    always_comb begin
        held_gate_next = held_gate_reg;
        eff_prev_next = gate_eff;
        // taken even under the reset input, so a hold that outlasts it freezes a current level
        if (eg.hold_on) begin
            held_gate_next = lv.gate;
        end
    end
    // the hold edge cycle still passes the live level; the frozen copy is only valid after it
    assign gate_eff = (lv.hold && !eg.hold_on) ? held_gate_reg : lv.gate;
    // a gate change made during hold takes effect at hold release
    assign gate_rise_eff = eff_prev_reg && !gate_eff && !lv.clear;
    assign gate_fall_eff = !eff_prev_reg && gate_eff && !lv.clear;
    assign take = sample_valid && !sup_reg && !lv.clear;

    // measurement path; reset input has priority, then hold
    always_comb begin
        win_next = win_reg;
        win_err_next = win_err_reg;
        win_any_next = win_any_reg;
        wmax_next = wmax_reg;
        wmin_next = wmin_reg;
        disp_next = disp_reg;
        dvalid_next = dvalid_reg;
        hold_val_next = hold_val_reg;
        hold_ok_next = hold_ok_reg;
        max_next = max_reg;
        min_next = min_reg;
        ext_next = ext_reg;
        alarm_next = alarm_reg;
        if (lv.clear) begin
            // discard data, extremes and alarm; no measurement at all
            win_next = 1'b0;
            win_any_next = 1'b0;
            win_err_next = 1'b0;
            dvalid_next = 1'b0;
            hold_ok_next = 1'b0;
            ext_next = 1'b0;
            alarm_next = 1'b0;
        end else begin
            alarm_next = alarm_reg | alarm_event;
            if (is_cont) begin
                // gate has no effect here
                if (eg.hold_on) begin
                    hold_val_next = disp_reg;
                    hold_ok_next = dvalid_reg && !scaling_error;
                end
                if (!lv.hold && take) begin
                    disp_next = sample_in;
                    dvalid_next = 1'b1;
                    if (!ext_reg || sample_in > max_reg) max_next = sample_in;
                    if (!ext_reg || sample_in < min_reg) min_next = sample_in;
                    ext_next = 1'b1;
                end
            end else if (mode_reg == event_trigger_pkg::SAMPLE_AND_HOLD_MODE) begin
                if (gate_fall_eff && take && !scaling_error) begin
                    disp_next = sample_in;
                    dvalid_next = 1'b1;
                    if (!ext_reg || sample_in > max_reg) max_next = sample_in;
                    if (!ext_reg || sample_in < min_reg) min_next = sample_in;
                    ext_next = 1'b1;
                end
            end else if (!lv.hold) begin
                if (gate_fall_eff) begin
                    win_next = 1'b1;
                    win_any_next = 1'b0;
                    win_err_next = 1'b0;
                end
                if ((win_reg || gate_fall_eff) && gate_eff) begin
                    if (scaling_error) win_err_next = 1'b1;
                    if (take && !scaling_error) begin
                        win_any_next = 1'b1;
                        if (!win_any_reg || sample_in > wmax_reg) wmax_next = sample_in;
                        if (!win_any_reg || sample_in < wmin_reg) wmin_next = sample_in;
                    end
                end
                if (gate_rise_eff && win_reg) begin
                    win_next = 1'b0;
                    if (win_any_reg && !win_err_reg && !scaling_error) begin
                        dvalid_next = 1'b1;
                        max_next = wmax_reg;
                        min_next = wmin_reg;
                        ext_next = 1'b1;
                        case (mode_reg)
                            event_trigger_pkg::MAX_HOLD_MODE: disp_next = wmax_reg;
                            event_trigger_pkg::MIN_HOLD_MODE: disp_next = wmin_reg;
                            event_trigger_pkg::SPAN_HOLD_MODE: disp_next = DW'(wmax_reg - wmin_reg);
                            default: disp_next = disp_reg;
                        endcase
                    end
                end
            end
        end
    end

    // dc follows the display; no data or reset input forces zero percent
    assign dc_prod = (disp_reg[DW-1]) ? '0 : (DW+OW)'($unsigned(disp_reg) * dc_gain);
    always_comb begin
        dc_next = dc_reg;
        if (lv.clear || !dvalid_reg) begin
            dc_next = event_trigger_pkg::DC_ZERO;
        end else if (!lv.hold) begin
            dc_next = (|dc_prod[DW+OW-1:OW]) ? {OW{1'b1}} : dc_prod[OW-1:0];
        end
    end

    // registers only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_reg <= event_trigger_pkg::CONTINUOUS_MODE;
            tick_reg <= '0;
            tenth_reg <= event_trigger_pkg::STARTUP_DEFAULT;
            sup_reg <= 1'b0;
            held_gate_reg <= 1'b0;
            eff_prev_reg <= 1'b0;
            win_reg <= 1'b0;
            win_err_reg <= 1'b0;
            win_any_reg <= 1'b0;
            wmax_reg <= '0;
            wmin_reg <= '0;
            disp_reg <= '0;
            dvalid_reg <= 1'b0;
            hold_val_reg <= '0;
            hold_ok_reg <= 1'b0;
            max_reg <= '0;
            min_reg <= '0;
            ext_reg <= 1'b0;
            alarm_reg <= 1'b0;
            dc_reg <= event_trigger_pkg::DC_ZERO;
        end else begin
            mode_reg <= mode_next;
            tick_reg <= tick_next;
            tenth_reg <= tenth_next;
            sup_reg <= sup_next;
            held_gate_reg <= held_gate_next;
            eff_prev_reg <= eff_prev_next;
            win_reg <= win_next;
            win_err_reg <= win_err_next;
            win_any_reg <= win_any_next;
            wmax_reg <= wmax_next;
            wmin_reg <= wmin_next;
            disp_reg <= disp_next;
            dvalid_reg <= dvalid_next;
            hold_val_reg <= hold_val_next;
            hold_ok_reg <= hold_ok_next;
            max_reg <= max_next;
            min_reg <= min_next;
            ext_reg <= ext_next;
            alarm_reg <= alarm_next;
            dc_reg <= dc_next;
        end
    end

    // continuous hold shows the captured value if data existed and no error was present at the hold edge
    // the hold edge cycle shows the live register, since hold_ok_reg may be left from an earlier hold
    assign show_held = is_cont && lv.hold && !eg.hold_on && hold_ok_reg;
    assign display_value = show_held ? hold_val_reg : disp_reg;
    assign display_valid = dvalid_reg;
    assign display_error = scaling_error && !show_held;
    assign display_burnout = burnout;
    assign max_value = max_reg;
    assign min_value = min_reg;
    assign extremes_valid = ext_reg;
    assign alarm_latched = alarm_reg;
    assign dc_out = dc_reg;
    assign gate_lamp = lv.gate;
    assign measuring = !lv.clear && !sup_reg && !lv.hold;
    assign mode = mode_reg;
endmodule : event_trigger_measure_hold

/* File: rtl/event_trigger_pkg.sv */
// Purpose: shared types and constants for the event trigger measure/hold block
// Assumes: 125 MHz system clock, signed readings of fixed width
// Notes: startup period is given in tenths of a second
package event_trigger_pkg;
    localparam int DATA_W = 20;
    localparam int CLK_HZ = 125000000;
    localparam int TENTH_S_CYCLES = CLK_HZ / 10;           // cycles per 0.1 s
    localparam int STARTUP_W = 10;                          // 0..999 tenths
    localparam logic [STARTUP_W-1:0] STARTUP_MAX = 10'h3E7; // 99.9 s
    localparam logic [STARTUP_W-1:0] STARTUP_DEFAULT = 10'h000;
    localparam int OUT_W = 16;                              // dc output code width
    localparam logic [OUT_W-1:0] DC_ZERO = 16'h0000;        // 0 percent

    // trigger mode setting, three bits
    localparam logic [2:0] CONTINUOUS_MODE = 3'h0;
    localparam logic [2:0] SAMPLE_AND_HOLD_MODE = 3'h1;
    localparam logic [2:0] MAX_HOLD_MODE = 3'h2;
    localparam logic [2:0] MIN_HOLD_MODE = 3'h3;
    localparam logic [2:0] SPAN_HOLD_MODE = 3'h4;

    // synchronised event levels, active high after inversion
    typedef struct packed {
        logic gate;
        logic startup;
        logic hold;
        logic clear;
    } event_levels_t;

    // one-cycle edges of the event levels
    typedef struct packed {
        logic gate_on;
        logic gate_off;
        logic startup_on;
        logic hold_on;
    } event_edges_t;
endpackage : event_trigger_pkg

/* File: verif/event_source.sv */
// Purpose: external controller that drives the four event pins
// Assumes: pins idle high as if pulled up
// Notes: one pin moves per call, just after a clock edge
`timescale 1ns/1ps
module event_source (
    input wire logic clk, // system clock
    output logic gate_n, // gate pin
    output logic startup_delay_in_n, // startup pin
    output logic hold_n, // hold pin
    output logic clear_n // clear pin
);
    // released pins read inactive, so start all high
    initial begin
        {gate_n, startup_delay_in_n, hold_n, clear_n} = 4'hF;
    end
    // pulls a pin low to assert it; 0 gate, 1 startup, 2 hold, 3 clear
    task automatic drive(input int idx, input logic on);
        @(posedge clk);
        #1;
        case (idx)
            0: gate_n = !on;
            1: startup_delay_in_n = !on;
            2: hold_n = !on;
            default: clear_n = !on;
        endcase
    endtask : drive
endmodule : event_source

/* File: verif/event_trigger_measure_hold_bench.sv */
// Purpose: self-checking bench for the event trigger measure/hold block
// Assumes: startup period kept at 0 or 1 tenth, dc gain of 2
// Notes: waits are padded past the three-edge pin latency
`timescale 1ns/1ps
module event_trigger_measure_hold_bench;
    logic clk, rst, mode_load, sample_valid, scaling_error, burnout, alarm_event;
    logic gate_n, startup_delay_in_n, hold_n, clear_n;
    logic [2:0] mode_sel, mode;
    logic [event_trigger_pkg::STARTUP_W-1:0] startup_tenths;
    logic signed [event_trigger_pkg::DATA_W-1:0] sample_in, display_value, max_value, min_value;
    logic display_valid, display_error, display_burnout, extremes_valid, alarm_latched, gate_lamp, measuring;
    logic [event_trigger_pkg::OUT_W-1:0] dc_gain, dc_out;
    int error_cnt, tests_run;
    event_trigger_measure_hold event_trigger_measure_hold_inst (.*);
    event_source event_source_inst (.*);
    // free running 125 MHz clock
    always #4 clk = ~clk;
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            error_cnt++;
        end
    endtask : chk
    task automatic chk_bit(input logic got, input logic exp);
        chk({19'h00000, got}, {19'h00000, exp});
    endtask : chk_bit
    task automatic ev(input int idx, input logic on);
        event_source_inst.drive(idx, on);
    endtask : ev
    task automatic smp(input logic [19:0] v);
        sample_in = v;
        sample_valid = 1'b1;
        cyc(1);
        sample_valid = 1'b0;
        cyc(1);
    endtask : smp
    task automatic load(input logic [2:0] m);
        mode_sel = m;
        mode_load = 1'b1;
        cyc(1);
        mode_load = 1'b0;
        cyc(1);
    endtask : load
    // one gate window of 5, 9, 2 in an extreme mode
    task automatic t_extreme(input logic [2:0] m, input logic [19:0] exp);
        load(m);
        ev(0, 1);
        cyc(3);
        smp(20'h00005);
        smp(20'h00009);
        smp(20'h00002);
        ev(0, 0);
        cyc(6);
        chk(display_value, exp);
        chk_bit(extremes_valid, 1'b1);
        chk(max_value, 20'h00009);
        chk(min_value, 20'h00002);
    endtask : t_extreme
    // codes above span are refused and leave the mode as it was
    task automatic t_modes;
        for (int m = 0; m < 6; m++) begin
            load(3'(m));
            chk({17'h00000, mode}, (m > 4) ? 20'h00004 : 20'(m));
        end
    endtask : t_modes
    // continuous: gate only lights the lamp, hold freezes, readings go on through an error
    task automatic t_continuous;
        load(3'h0);
        ev(0, 1);
        cyc(3);
        chk_bit(gate_lamp, 1'b1);
        smp(20'h00123);
        cyc(3);
        chk(display_value, 20'h00123);
        chk({4'h0, dc_out}, 20'h00246);
        ev(0, 0);
        ev(2, 1);
        cyc(4);
        smp(20'h00456);
        cyc(3);
        chk(display_value, 20'h00123);
        ev(2, 0);
        cyc(4);
        smp(20'h00456);
        cyc(3);
        chk(display_value, 20'h00456);
        scaling_error = 1'b1;
        smp(20'h000AB);
        cyc(1);
        chk(display_value, 20'h000AB);
        chk_bit(display_error, 1'b1);
        scaling_error = 1'b0;
        cyc(1);
        chk_bit(display_error, 1'b0);
    endtask : t_continuous
    // gate closes during a scaling error, the old span must remain
    task automatic t_gate_error;
        ev(0, 1);
        cyc(3);
        smp(20'h00050);
        smp(20'h00001);
        scaling_error = 1'b1;
        ev(0, 0);
        cyc(6);
        scaling_error = 1'b0;
        chk(display_value, 20'h00007);
    endtask : t_gate_error
    // gate frozen active by hold and released under it: the window closes at hold release
    task automatic t_hold_gate;
        load(3'h2);
        ev(0, 1);
        cyc(3);
        smp(20'h00011);
        ev(2, 1);
        cyc(3);
        ev(0, 0);
        cyc(4);
        chk(display_value, 20'h00007);
        ev(2, 0);
        cyc(4);
        chk(display_value, 20'h00011);
    endtask : t_hold_gate
    // sample-and-hold keeps the reading present at the gate falling edge
    task automatic t_sample_hold;
        load(3'h1);
        sample_in = 20'h00033;
        sample_valid = 1'b1;
        ev(0, 1);
        cyc(4);
        sample_in = 20'h00044;
        cyc(3);
        chk(display_value, 20'h00033);
        sample_valid = 1'b0;
        ev(0, 0);
    endtask : t_sample_hold
    // reset input discards data and alarm, burnout still shown, gate under it ignored
    task automatic t_clear;
        alarm_event = 1'b1;
        cyc(1);
        alarm_event = 1'b0;
        cyc(2);
        chk_bit(alarm_latched, 1'b1);
        ev(3, 1);
        cyc(6);
        burnout = 1'b1;
        ev(0, 1);
        cyc(6);
        chk_bit(display_burnout, 1'b1);
        chk({4'h0, dc_out}, 20'h00000);
        chk({17'h00000, display_valid, extremes_valid, alarm_latched}, 20'h00000);
        burnout = 1'b0;
        ev(0, 0);
        ev(3, 0);
        cyc(6);
        chk_bit(display_valid, 1'b0);
    endtask : t_clear
    // startup input stops readings; after a mid-run reset a zero period suppresses nothing
    task automatic t_startup;
        load(3'h0);
        startup_tenths = 10'h001;
        ev(1, 1);
        cyc(4);
        smp(20'h00077);
        cyc(3);
        chk_bit(measuring, 1'b0);
        chk_bit(display_valid, 1'b0);
        rst = 1'b1;
        cyc(2);
        rst = 1'b0;
        startup_tenths = 10'h000;
        ev(1, 0);
        cyc(2);
        chk_bit(measuring, 1'b1);
    endtask : t_startup
    task automatic stop_test;
        if (error_cnt == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : stop_test
    // watchdog sized well beyond the two hundred or so cycles the run needs
    initial begin
        #200000;
        error_cnt++;
        stop_test;
    end
    // main sequence; every input set at time zero
    initial begin
        {clk, mode_load, sample_valid, scaling_error, burnout, alarm_event} = 6'h00;
        {mode_sel, startup_tenths, sample_in} = 33'h000000000;
        dc_gain = 16'h0002;
        rst = 1'b1;
        repeat (20) @(posedge clk);
        #1;
        rst = 1'b0;
        chk({17'h00000, mode}, 20'h00000);
        chk({4'h0, dc_out}, 20'h00000);
        t_modes;
        t_continuous;
        t_extreme(3'h2, 20'h00009);
        t_extreme(3'h3, 20'h00002);
        t_extreme(3'h4, 20'h00007);
        t_gate_error;
        t_hold_gate;
        t_sample_hold;
        t_clear;
        t_startup;
        stop_test;
    end
endmodule : event_trigger_measure_hold_bench

/* File: verif/event_trigger_measure_hold_properties.sv */
// Purpose: port assertions for the event trigger measure/hold block
// Assumes: one clock domain, rst async active high
// Notes: pins pass two sync flops, so their effects lag three edges
`timescale 1ns/1ps
module event_trigger_measure_hold_properties (
    input wire logic clk, // clock
    input wire logic rst, // reset
    input wire logic gate_n, // gate pin
    input wire logic startup_delay_in_n, // startup pin
    input wire logic hold_n, // hold pin
    input wire logic clear_n, // clear pin
    input wire logic [2:0] mode_sel, // mode request
    input wire logic mode_load, // mode strobe
    input wire logic [event_trigger_pkg::STARTUP_W-1:0] startup_tenths, // startup period
    input wire logic signed [event_trigger_pkg::DATA_W-1:0] sample_in, // reading
    input wire logic sample_valid, // reading strobe
    input wire logic scaling_error, // scaling error
    input wire logic burnout, // burnout
    input wire logic [2:0] mode, // active mode
    input wire logic signed [event_trigger_pkg::DATA_W-1:0] display_value, // shown value
    input wire logic display_valid, // data exists
    input wire logic display_burnout, // burnout shown
    input wire logic signed [event_trigger_pkg::DATA_W-1:0] max_value, // maximum
    input wire logic signed [event_trigger_pkg::DATA_W-1:0] min_value, // minimum
    input wire logic extremes_valid, // extremes held
    input wire logic alarm_latched, // alarm
    input wire logic [event_trigger_pkg::OUT_W-1:0] dc_out, // dc code
    input wire logic gate_lamp, // lamp
    input wire logic measuring // taking readings
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // settle windows are long enough for a pin to cross the synchroniser
    sequence s_cleared; !clear_n[*6]; endsequence
    sequence s_quiet; (hold_n && clear_n && !scaling_error)[*4]; endsequence
    property p_lamp; ($fell(gate_n) && clear_n) ##1 (!gate_n && clear_n)[*2] |-> gate_lamp; endproperty
    a_lamp: assert property (p_lamp) else $error("gate lamp dark");
    property p_clear;
        s_cleared |-> !measuring && !display_valid && !extremes_valid && !alarm_latched && dc_out == 16'h0000;
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not discard");
    property p_burn; s_cleared ##0 $rose(burnout) |-> display_burnout ##1 $stable(dc_out); endproperty
    a_burn: assert property (p_burn) else $error("burnout under clear wrong");
    property p_mode; mode_load && mode_sel <= 3'h4 |=> mode == $past(mode_sel); endproperty
    a_mode: assert property (p_mode) else $error("mode not taken");
    property p_mode_bad; mode_load && mode_sel > 3'h4 |=> $stable(mode); endproperty
    a_mode_bad: assert property (p_mode_bad) else $error("bad mode taken");
    property p_cont;
        hold_n[*3] ##0 (mode == 3'h0 && sample_valid && measuring && !scaling_error) |=>
            display_value == $past(sample_in);
    endproperty
    a_cont: assert property (p_cont) else $error("continuous reading lost");
    property p_hold;
        (!hold_n && clear_n)[*6] |-> $stable(display_value) && $stable(max_value) && $stable(min_value)
            && $stable(dc_out);
    endproperty
    a_hold: assert property (p_hold) else $error("held values moved");
    property p_extreme;
        s_quiet ##0 ($fell(gate_lamp) && extremes_valid && mode >= 3'h2) |-> ##[1:3]
            (mode == 3'h2 && display_value == max_value) || (mode == 3'h3 && display_value == min_value)
            || (mode == 3'h4 && display_value == max_value - min_value);
    endproperty
    a_extreme: assert property (p_extreme) else $error("extreme result wrong");
    property p_sh;
        s_quiet ##0 (mode == 3'h1 && $rose(gate_lamp) && sample_valid && measuring) |=>
            display_value == $past(sample_in);
    endproperty
    a_sh: assert property (p_sh) else $error("sample not captured");
    property p_startup;
        $fell(startup_delay_in_n) && hold_n && clear_n && startup_tenths == 10'h001 |-> ##4 !measuring[*8];
    endproperty
    a_startup: assert property (p_startup) else $error("startup not suppressing");
endmodule : event_trigger_measure_hold_properties

bind event_trigger_measure_hold event_trigger_measure_hold_properties event_trigger_measure_hold_properties_inst (.*);
